// File: taal_alarm.sv
`timescale 1ns/1ns
`default_nettype none
`include "taal_cfg.svh"

module taal_alarm #(
    parameter logic ADDR_LSB = 1'b0
) (
    input  wire logic                ref_clk,
    input  wire logic                arst_n,
    input  wire logic                smbClk,
    input  wire logic                sdaIn,
    output logic                     sdaOut,
    output logic                     sdaOe,
    output logic                     alertOut,
    output logic                     alertOe,
    output logic                     critOut,
    output logic                     critOe,
    input  wire taal_pkg::taal_conv_t conv
);
    localparam logic [6:0] SLAVE_ADDR = {`TAAL_ADDR_HI, ADDR_LSB};

    taal_pkg::taal_state_t st;
    taal_pkg::taal_state_t next_st;

    logic              sclRise;
    logic              sclFall;
    logic              startCond;
    logic              stopCond;
    logic              statusRead;
    logic              araDone;
    logic              araLost;
    logic              cmpMode;
    logic              ch;
    logic [7:0]        statusByte;
    logic [7:0]        linkByte;
    logic              linkTgl;
    logic signed [12:0] samp;
    logic signed [12:0] limHi;
    logic signed [12:0] limLo;
    logic signed [12:0] limCr;
    logic signed [12:0] limRel;
    logic              overHi;
    logic              underLo;
    logic              overCr;

    // ----------------------------------------
    // Link-domain capture
    // ----------------------------------------
    taal_link_rx u_link (
        .smbClk   (smbClk),
        .frameRst (st.frameRst),
        .sdaIn    (sdaIn),
        .byteOut  (linkByte),
        .byteTgl  (linkTgl)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic signed [12:0] scale8(input logic [7:0] v);
        return {v[7], v[7], v, 3'b000};
    endfunction

    function automatic logic [7:0] regRd(
        input logic [7:0]            ptr,
        input taal_pkg::taal_state_t s
    );
        logic [7:0] r;
        r = 8'h00;
        case (ptr)
            `TAAL_REG_LOCAL_READ:  r = s.localRd;
            `TAAL_REG_REMOTE_HI:   r = s.remoteRd[10:3];
            `TAAL_REG_REMOTE_LO:   r = {s.remoteRd[2:0], 5'b00000};
            `TAAL_REG_STATUS:      r = {s.busy, s.flags};
            `TAAL_REG_LOCAL_HIGH:  r = s.hiL;
            `TAAL_REG_LOCAL_LOW:   r = s.loL;
            `TAAL_REG_LOCAL_CRIT:  r = s.crL;
            `TAAL_REG_REMOTE_HIGH: r = s.hiR;
            `TAAL_REG_REMOTE_LOW:  r = s.loR;
            `TAAL_REG_REMOTE_CRIT: r = s.crR;
            `TAAL_REG_HYST:        r = s.hyst;
            `TAAL_REG_CONFIG:      r = s.cfgReg;
            `TAAL_REG_SETUP:       r = s.setupReg;
            default:               r = 8'h00;
        endcase
        return r;
    endfunction

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        next_st    = st;
        statusRead = 1'b0;
        araDone    = 1'b0;
        araLost    = 1'b0;
        cmpMode    = st.setupReg[`TAAL_SETUP_CMP];
        statusByte = {st.busy, st.flags};

        next_st.sclSync = {st.sclSync[1:0], smbClk};
        next_st.sdaSync = {st.sdaSync[1:0], sdaIn};
        if (st.sclSync[1] == st.sclSync[2]) begin
            next_st.sclF = st.sclSync[2];
        end
        if (st.sdaSync[1] == st.sdaSync[2]) begin
            next_st.sdaF = st.sdaSync[2];
        end
        sclRise   = !st.sclF && next_st.sclF;
        sclFall   = st.sclF && !next_st.sclF;
        startCond = st.sclF && next_st.sclF && st.sdaF && !next_st.sdaF;
        stopCond  = st.sclF && next_st.sclF && !st.sdaF && next_st.sdaF;

        next_st.tglSync = {st.tglSync[1:0], linkTgl};
        if (st.tglSync[1] == st.tglSync[2] &&
            st.tglSync[2] != st.tglSeen) begin
            next_st.tglSeen = st.tglSync[2];
            next_st.rxByte  = linkByte;
        end

        // Link capture held clear from start until clock falls
        next_st.frameRst = (st.phase == taal_pkg::TAAL_IDLE) ||
                           startCond || (st.frameRst && !sclFall);

        if (startCond) begin
            next_st.phase  = taal_pkg::TAAL_ADDR;
            next_st.bitCnt = 4'd0;
            next_st.sdaOe  = 1'b0;
        end else if (stopCond) begin
            next_st.phase = taal_pkg::TAAL_IDLE;
            next_st.sdaOe = 1'b0;
        end else if (st.phase != taal_pkg::TAAL_IDLE && sclRise) begin
            if (st.bitCnt < 4'd9) begin
                next_st.bitCnt = st.bitCnt + 4'd1;
            end
            if (st.phase == taal_pkg::TAAL_ARA && st.bitCnt < 4'd8) begin
                if (next_st.sdaF != st.txByte[3'd7 - st.bitCnt[2:0]]) begin
                    araLost       = 1'b1;
                    next_st.phase = taal_pkg::TAAL_IGNORE;
                    next_st.sdaOe = 1'b0;
                end else if (st.bitCnt == 4'd7) begin
                    araDone = 1'b1;
                end
            end
            if (st.phase == taal_pkg::TAAL_RDATA && st.bitCnt == 4'd8) begin
                next_st.masterAck = !next_st.sdaF;
            end
        end else if (st.phase != taal_pkg::TAAL_IDLE && sclFall) begin
            next_st.sdaOe = 1'b0;
            case (st.bitCnt)
                4'd8: begin
                    case (st.phase)
                        taal_pkg::TAAL_ADDR: begin
                            if (st.rxByte[7:1] == SLAVE_ADDR) begin
                                next_st.sdaOe     = 1'b1;
                                next_st.masterAck = 1'b1;
                                next_st.phase     = st.rxByte[0] ?
                                    taal_pkg::TAAL_RDATA :
                                    taal_pkg::TAAL_CMD;
                            // answer address for the alert query
                            end else if (st.rxByte[7:1] == `TAAL_ARA_ADDR &&
                                         st.rxByte[0] && !cmpMode &&
                                         st.alertOe) begin
                                next_st.sdaOe     = 1'b1;
                                next_st.masterAck = 1'b1;
                                next_st.txByte    = {SLAVE_ADDR, 1'b0};
                                next_st.phase     = taal_pkg::TAAL_ARA;
                            end else begin
                                next_st.phase = taal_pkg::TAAL_IGNORE;
                            end
                        end
                        taal_pkg::TAAL_CMD: begin
                            next_st.cmdPtr = st.rxByte;
                            next_st.sdaOe  = 1'b1;
                            next_st.phase  = taal_pkg::TAAL_WDATA;
                        end
                        taal_pkg::TAAL_WDATA: begin
                            next_st.sdaOe = 1'b1;
                            case (st.cmdPtr)
                                `TAAL_REG_LOCAL_HIGH:  next_st.hiL = st.rxByte;
                                `TAAL_REG_LOCAL_LOW:   next_st.loL = st.rxByte;
                                `TAAL_REG_LOCAL_CRIT:  next_st.crL = st.rxByte;
                                `TAAL_REG_REMOTE_HIGH: next_st.hiR = st.rxByte;
                                `TAAL_REG_REMOTE_LOW:  next_st.loR = st.rxByte;
                                `TAAL_REG_REMOTE_CRIT: next_st.crR = st.rxByte;
                                `TAAL_REG_HYST:        next_st.hyst = st.rxByte;
                                `TAAL_REG_CONFIG:  next_st.cfgReg = st.rxByte;
                                `TAAL_REG_SETUP:   next_st.setupReg = st.rxByte;
                                default:           next_st.hyst = st.hyst;
                            endcase
                        end
                        default: next_st.sdaOe = 1'b0;
                    endcase
                end
                4'd9: begin
                    next_st.bitCnt = 4'd0;
                    if ((st.phase == taal_pkg::TAAL_RDATA ||
                         st.phase == taal_pkg::TAAL_ARA) && st.masterAck) begin
                        if (st.phase == taal_pkg::TAAL_RDATA) begin
                            next_st.txByte = regRd(st.cmdPtr, st);
                            next_st.sdaOe  = !next_st.txByte[7];
                            statusRead = (st.cmdPtr == `TAAL_REG_STATUS);
                        end else begin
                            next_st.sdaOe     = !st.txByte[7];
                            next_st.masterAck = 1'b0;
                        end
                    end else if (st.phase == taal_pkg::TAAL_RDATA ||
                                 st.phase == taal_pkg::TAAL_ARA) begin
                        next_st.phase = taal_pkg::TAAL_IGNORE;
                    end
                end
                default: begin
                    if ((st.phase == taal_pkg::TAAL_RDATA ||
                         st.phase == taal_pkg::TAAL_ARA) &&
                        st.bitCnt != 4'd0) begin
                        next_st.sdaOe = !st.txByte[3'd7 - st.bitCnt[2:0]];
                    end
                end
            endcase
        end

        // in interrupt mode, read of a live status masks alert
        if (statusRead && !cmpMode &&
            |(statusByte & `TAAL_ALERT_BITS)) begin
            next_st.cfgReg[`TAAL_CFG_MASK] = 1'b1;
        end
        if (araDone) begin
            next_st.cfgReg[`TAAL_CFG_MASK] = 1'b1;
        end
        // clear, release and mask in one read
        // read clears; a same-cycle set wins below
        if (statusRead) begin
            next_st.flags[6:2] = 5'b00000;
            next_st.critPend   = st.flags[1:0];
        end

        next_st.busy = conv.busy;
        ch    = conv.remote;
        samp  = ch ? {{2{conv.remoteVal[10]}}, conv.remoteVal} :
                     scale8(conv.localVal);
        limHi = scale8(ch ? st.hiR : st.hiL);
        limLo = scale8(ch ? st.loR : st.loL);
        limCr = scale8(ch ? st.crR : st.crL);
        limRel = limCr - $signed({2'b00, st.hyst, 3'b000});
        overHi  = samp > limHi;
        underLo = samp < limLo;
        overCr  = samp > limCr;

        if (conv.done) begin
            if (ch) begin
                next_st.remoteRd = conv.remoteVal;
            end else begin
                next_st.localRd = conv.localVal;
            end
            if (overHi) begin
                next_st.flags[ch ? `TAAL_ST_RHIGH : `TAAL_ST_LHIGH] = 1'b1;
            end
            if (underLo) begin
                next_st.flags[ch ? `TAAL_ST_RLOW : `TAAL_ST_LLOW] = 1'b1;
            end
            // critical flag holds until read and cool
            if (overCr) begin
                next_st.flags[ch]    = 1'b1;
                next_st.critPend[ch] = 1'b0;
            end else if (next_st.critPend[ch]) begin
                next_st.flags[ch]    = 1'b0;
                next_st.critPend[ch] = 1'b0;
            end
            if (overCr) begin
                next_st.critAct[ch] = 1'b1;
            end else if (samp < limRel) begin
                next_st.critAct[ch] = 1'b0;
            end
            next_st.violAct[ch] = overHi || underLo || overCr;
        end

        next_st.alertOe = !st.cfgReg[`TAAL_CFG_MASK] &&
            (cmpMode ? |st.violAct :
                       |({1'b0, st.flags} & `TAAL_ALERT_BITS));
        next_st.critOe = |st.critAct;
        next_st.drvLow = 1'b0;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st          <= '0;
            st.sclSync  <= 3'h7;
            st.sdaSync  <= 3'h7;
            st.sclF     <= 1'b1;
            st.sdaF     <= 1'b1;
            st.frameRst <= 1'b1;
            st.phase    <= taal_pkg::TAAL_IDLE;
            st.cfgReg   <= `TAAL_RST_CONFIG;
            st.setupReg <= `TAAL_RST_SETUP;
            st.hiL      <= `TAAL_RST_HIGH;
            st.loL      <= `TAAL_RST_LOW;
            st.crL      <= `TAAL_RST_CRIT;
            st.hiR      <= `TAAL_RST_HIGH;
            st.loR      <= `TAAL_RST_LOW;
            st.crR      <= `TAAL_RST_CRIT;
            st.hyst     <= `TAAL_RST_HYST;
        end else begin
            st <= next_st;
        end
    end

    // Open-drain pins only ever pull low
    assign sdaOut   = st.drvLow;
    assign alertOut = st.drvLow;
    assign critOut  = st.drvLow;
    assign sdaOe    = st.sdaOe;
    assign alertOe  = st.alertOe;
    assign critOe   = st.critOe;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_mask_quiet;
        st.cfgReg[`TAAL_CFG_MASK] |=> !alertOe;
    endproperty
    a_mask_quiet: assert property (p_mask_quiet)
        else $error("alert driven while masked");

    property p_cmp_release;
        cmpMode && !(|st.violAct) |=> !alertOe;
    endproperty
    a_cmp_release: assert property (p_cmp_release)
        else $error("comparator alert not released");

    property p_int_alert;
        !cmpMode && !st.cfgReg[`TAAL_CFG_MASK] &&
        (|({1'b0, st.flags} & `TAAL_ALERT_BITS)) |=> alertOe;
    endproperty
    a_int_alert: assert property (p_int_alert)
        else $error("flag set but alert idle");

    property p_read_mask;
        statusRead && !cmpMode && (|(statusByte & `TAAL_ALERT_BITS))
        |=> st.cfgReg[`TAAL_CFG_MASK] ##1 !alertOe;
    endproperty
    a_read_mask: assert property (p_read_mask)
        else $error("status read did not mask and release");

    property p_read_clear;
        statusRead && !conv.done |=> st.flags[6:2] == 5'b00000;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("status read left flags set");

    property p_crit_on;
        conv.done && overCr |=> st.critAct[$past(ch)] ##1 critOe;
    endproperty
    a_crit_on: assert property (p_crit_on)
        else $error("critical output missed");

    property p_crit_hold;
        conv.done && !overCr && !(samp < limRel) &&
        st.critAct[ch] |=> st.critAct[$past(ch)];
    endproperty
    a_crit_hold: assert property (p_crit_hold)
        else $error("critical released inside hysteresis");

    property p_ara_done;
        araDone |=> st.cfgReg[`TAAL_CFG_MASK] ##1 !alertOe;
    endproperty
    a_ara_done: assert property (p_ara_done)
        else $error("alert kept after address sent");

    property p_ara_lost;
        araLost |=> !sdaOe && st.phase == taal_pkg::TAAL_IGNORE &&
            st.cfgReg[`TAAL_CFG_MASK] == $past(st.cfgReg[`TAAL_CFG_MASK]);
    endproperty
    a_ara_lost: assert property (p_ara_lost)
        else $error("lost arbitration not handled");

    property p_ara_mode;
        st.phase == taal_pkg::TAAL_ARA |-> !cmpMode;
    endproperty
    a_ara_mode: assert property (p_ara_mode)
        else $error("alert query answered in comparator mode");

    c_status_read: cover property (statusRead ##1 st.cfgReg[7]);
    c_ara_done:    cover property (araDone);
    c_crit:        cover property (conv.done && overCr ##2 critOe);

endmodule
`default_nettype wire

// File: taal_cfg.svh
`ifndef TAAL_CFG_SVH
`define TAAL_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TAAL_REG_LOCAL_READ   8'h00
`define TAAL_REG_REMOTE_HI    8'h01
`define TAAL_REG_STATUS       8'h02
`define TAAL_REG_LOCAL_HIGH   8'h05
`define TAAL_REG_LOCAL_LOW    8'h06
`define TAAL_REG_REMOTE_HIGH  8'h07
`define TAAL_REG_REMOTE_LOW   8'h08
`define TAAL_REG_CONFIG       8'h09
`define TAAL_REG_REMOTE_LO    8'h10
`define TAAL_REG_REMOTE_CRIT  8'h19
`define TAAL_REG_LOCAL_CRIT   8'h20
`define TAAL_REG_HYST         8'h21
`define TAAL_REG_SETUP        8'hBF

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TAAL_ST_BUSY          7
`define TAAL_ST_LHIGH         6
`define TAAL_ST_LLOW          5
`define TAAL_ST_RHIGH         4
`define TAAL_ST_RLOW          3
`define TAAL_CFG_MASK         7
`define TAAL_SETUP_CMP        0
`define TAAL_ALERT_BITS       8'h7B

// ----------------------------------------
// Addresses and reset values
// ----------------------------------------
`define TAAL_ARA_ADDR         7'h0C
`define TAAL_ADDR_HI          6'h26
`define TAAL_RST_CONFIG       8'h00
`define TAAL_RST_SETUP        8'h00
`define TAAL_RST_HIGH         8'h46
`define TAAL_RST_LOW          8'h00
`define TAAL_RST_CRIT         8'h55
`define TAAL_RST_HYST         8'h0A

`endif

// File: taal_pkg.sv
`default_nettype none

package taal_pkg;

    typedef enum logic [2:0] {
        TAAL_IDLE,
        TAAL_ADDR,
        TAAL_CMD,
        TAAL_WDATA,
        TAAL_RDATA,
        TAAL_ARA,
        TAAL_IGNORE
    } taal_phase_t;

    // Result of one conversion, from the conversion timebase
    typedef struct packed {
        logic        done;
        logic        remote;
        logic        busy;
        logic [7:0]  localVal;
        logic [10:0] remoteVal;
    } taal_conv_t;

    typedef struct packed {
        logic [7:0] shift;
        logic [3:0] cnt;
        logic [7:0] byteOut;
        logic       tgl;
    } taal_link_t;

    typedef struct packed {
        logic [2:0]  sclSync;
        logic [2:0]  sdaSync;
        logic        sclF;
        logic        sdaF;
        logic [2:0]  tglSync;
        logic        tglSeen;
        logic [7:0]  rxByte;
        logic        frameRst;
        taal_phase_t phase;
        logic [3:0]  bitCnt;
        logic [7:0]  txByte;
        logic [7:0]  cmdPtr;
        logic        masterAck;
        logic [7:0]  localRd;
        logic [10:0] remoteRd;
        logic        busy;
        logic [7:0]  cfgReg;
        logic [7:0]  setupReg;
        logic [7:0]  hiL;
        logic [7:0]  loL;
        logic [7:0]  crL;
        logic [7:0]  hiR;
        logic [7:0]  loR;
        logic [7:0]  crR;
        logic [7:0]  hyst;
        logic [6:0]  flags;
        logic [1:0]  critPend;
        logic [1:0]  critAct;
        logic [1:0]  violAct;
        logic        alertOe;
        logic        critOe;
        logic        sdaOe;
        logic        drvLow;
    } taal_state_t;

endpackage

`default_nettype wire

// File: taal_link_rx.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Bit capture on the bus clock
// ----------------------------------------
module taal_link_rx (
    input  wire logic       smbClk,
    input  wire logic       frameRst,
    input  wire logic       sdaIn,
    output logic [7:0]      byteOut,
    output logic            byteTgl
);
    taal_pkg::taal_link_t st;
    taal_pkg::taal_link_t next_st;

    // Byte stays stable a whole bit time, so the toggle
    // alone needs synchronising on the other side
    always_comb begin
        next_st = st;
        if (st.cnt == 4'd7) begin
            next_st.byteOut = {st.shift[6:0], sdaIn};
            next_st.tgl     = ~st.tgl;
            next_st.cnt     = 4'd8;
        end else if (st.cnt == 4'd8) begin
            next_st.cnt = 4'd0;
        end else begin
            next_st.shift = {st.shift[6:0], sdaIn};
            next_st.cnt   = st.cnt + 4'd1;
        end
    end

    // Cleared by each start; release happens with clock low
    always_ff @(posedge smbClk or posedge frameRst) begin
        if (frameRst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign byteOut = st.byteOut;
    assign byteTgl = st.tgl;

endmodule
`default_nettype wire

// File: taal_smb_host.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Bus host model
// ----------------------------------------
module taal_smb_host (
    output logic      smbClk,
    output logic      sdaHost,
    input  wire logic sdaLine
);
    initial begin
        smbClk  = 1'b1;
        sdaHost = 1'b1;
    end
    task automatic bit_x(input logic b, output logic r);
        #40 sdaHost = b;
        #40 smbClk = 1'b1;
        #40 r = sdaLine;
        #40 smbClk = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] w, output logic [7:0] r,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(w[i], r[i]);
        end
        // Always released: single-byte reads end refused
        bit_x(1'b1, ack);
    endtask
    task automatic start_c();
        sdaHost = 1'b1;
        #40 smbClk = 1'b1;
        #80 sdaHost = 1'b0;
        #80 smbClk = 1'b0;
    endtask
    // Clock stands high between frames
    task automatic stop_c();
        sdaHost = 1'b0;
        #40 smbClk = 1'b1;
        #80 sdaHost = 1'b1;
        #160;
    endtask
endmodule
`default_nettype wire

// File: taal_alarm_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module taal_alarm_tb_top;
    logic ref_clk, arst_n, smbClk, sdaHost, sdaIn, sdaOe, alertOe, critOe;
    logic sdaOut, alertOut, critOut;
    logic                 k;
    logic [7:0]           r;
    taal_pkg::taal_conv_t conv;
    int                   n_mismatch = 0;
    int                   checked = 0;
    // Pull-up on the data wire; pulled low by the host or by an enabled low pin
    assign sdaIn = sdaHost & ~(sdaOe & ~sdaOut);
    taal_alarm i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .smbClk(smbClk),
        .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .alertOut(alertOut),
        .alertOe(alertOe), .critOut(critOut), .critOe(critOe), .conv(conv));
    taal_smb_host h (.smbClk(smbClk), .sdaHost(sdaHost), .sdaLine(sdaIn));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic conclude();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        h.start_c();
        h.xfer(8'h98, r, k);
        h.xfer(a, r, k);
        h.xfer(d, r, k);
        h.stop_c();
        chk({7'h00, k}, 8'h00);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        h.start_c();
        h.xfer(8'h98, r, k);
        h.xfer(a, r, k);
        h.start_c();
        h.xfer(8'h99, r, k);
        h.xfer(8'hFF, r, k);
        h.stop_c();
        chk(r, e);
    endtask
    // A zero in w stands for a rival that wins the address race
    task automatic ara(input logic [7:0] w, input logic [7:0] e);
        h.start_c();
        h.xfer(8'h19, r, k);
        h.xfer(w, r, k);
        h.stop_c();
        chk(r, e);
    endtask
    task automatic cv(input logic rm, input logic [7:0] lv,
                      input logic [10:0] rv);
        @(posedge ref_clk) #1 conv = '{1'b1, rm, 1'b0, lv, rv};
        @(posedge ref_clk) #1 conv.done = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    initial begin
        #250000;
        n_mismatch++;
        conclude();
    end
    initial begin
        conv = '0;
        arst_n = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1 arst_n = 1'b1;
        repeat (8) @(posedge ref_clk);
        rd(8'h09, 8'h00);
        rd(8'hBF, 8'h00);
        cv(1'b0, 8'h50, 11'h000);
        chk({7'h00, alertOe}, 8'h01);
        chk({6'h00, alertOut, critOut}, 8'h00);
        rd(8'h02, 8'h40);
        chk({7'h00, alertOe}, 8'h00);
        rd(8'h09, 8'h80);
        rd(8'h02, 8'h00);
        @(posedge ref_clk) #1 conv.busy = 1'b1;
        rd(8'h02, 8'h80);
        cv(1'b0, 8'h50, 11'h000);
        chk({7'h00, alertOe}, 8'h00);
        wr(8'h09, 8'h00);
        chk({7'h00, alertOe}, 8'h01);
        ara(8'h00, 8'h00);
        chk({7'h00, alertOe}, 8'h01);
        ara(8'hFF, 8'h98);
        chk({7'h00, alertOe}, 8'h00);
        rd(8'h09, 8'h80);
        cv(1'b0, 8'h60, 11'h000);
        chk({7'h00, critOe}, 8'h01);
        rd(8'h02, 8'h41);
        cv(1'b0, 8'h50, 11'h000);
        chk({7'h00, critOe}, 8'h01);
        rd(8'h02, 8'h40);
        cv(1'b0, 8'h40, 11'h000);
        chk({7'h00, critOe}, 8'h00);
        wr(8'h00, 8'h12);
        rd(8'h00, 8'h40);
        cv(1'b1, 8'h40, 11'h7FF);
        rd(8'h01, 8'hFF);
        rd(8'h10, 8'hE0);
        wr(8'h05, 8'h3C);
        rd(8'h05, 8'h3C);
        wr(8'hBF, 8'h01);
        wr(8'h09, 8'h00);
        cv(1'b0, 8'h50, 11'h000);
        chk({7'h00, alertOe}, 8'h01);
        ara(8'hFF, 8'hFF);
        cv(1'b0, 8'h30, 11'h000);
        cv(1'b1, 8'h30, 11'h000);
        chk({7'h00, alertOe}, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
